// *** pwmart_checker.sv ***
// Assertion checker for the auto-reload PWM timer, bound to its top module.
// Assumes one AXI4-Lite write and one read at a time.
`timescale 1ns/100ps
module pwmart_checker
  import pwmart_pkg::*;
#(
  parameter int NCH  = PWMART_CHANNELS,
  parameter int NCAP = PWMART_CAPS
)(
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [PWMART_ADDR_W-1:0] s_axi_araddr,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic [NCH-1:0]           pwm_output_pin,
  input wire logic [NCH-1:0]           pwm_output_oe_n,
  input wire logic                     overflow_irq,
  input wire logic [NCAP-1:0]          capture_irq
);
  localparam logic [11:0] CS_A = {IDX_CTRL_STAT, 2'b00};
  localparam logic [11:0] CR_A = {IDX_CAP_RES1, 2'b00};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_lat;
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response late or early");
  property p_r_lat;
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late or upper bits set");
  property p_b_hold;
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped or changed");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("new write accepted during response");
  property p_oe_pin;
    (pwm_output_pin & pwm_output_oe_n & $past(pwm_output_oe_n)) == '0;
  endproperty
  a_oe_pin: assert property (p_oe_pin) else $error("disabled channel shows a level");
  property p_ovf_clr;
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == CS_A) |-> ##2 !overflow_irq;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("status read left overflow request");
  property p_cap_clr;
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == CR_A) |-> ##2 !capture_irq[0];
  endproperty
  a_cap_clr: assert property (p_cap_clr) else $error("result read left capture request");
endmodule : pwmart_checker

bind pwmart_top pwmart_checker #(.NCH(NCH), .NCAP(NCAP)) pwmart_checker_inst (.*);

// *** pwmart_far_side.sv ***
// Far-side model of the PWM timer: PWM loads, capture signal sources and the external count clock.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/100ps
module pwmart_far_side
  import pwmart_pkg::*;
(
  input  wire logic                       aclk,
  input  wire logic [PWMART_CHANNELS-1:0] pwm_level,
  input  wire logic [PWMART_CHANNELS-1:0] pwm_oe_n,
  output logic                            ext_clk,
  output logic [PWMART_CAPS-1:0]          cap_level
);
  int hi_cnt [PWMART_CHANNELS];

  initial
  begin
    ext_clk   = 1'b0;
    cap_level = '0;
    foreach (hi_cnt[i]) hi_cnt[i] = 0;
  end

  // A load sees a level only while the pin is driven; deferred update keeps bench reads race free.
  always @(posedge aclk)
    foreach (hi_cnt[i])
      if (!pwm_oe_n[i] && pwm_level[i])
        hi_cnt[i] <= hi_cnt[i] + 1;

  // The count clock stands still between bursts and is slower than half the system clock.
  task automatic ext_burst(input int n);
    repeat (n)
    begin
      #100 ext_clk = 1'b1;
      #100 ext_clk = 1'b0;
    end
  endtask : ext_burst

  task automatic set_cap(input int i, input logic v);
    cap_level[i] <= v;
  endtask : set_cap
endmodule : pwmart_far_side

// *** pwmart_pkg.sv ***
// Constants, register map and carrier types of the 8-bit auto-reload PWM timer.
// Assumes a 32-bit AXI4-Lite master; each 8-bit register sits in the low byte of one word.
// Operation
// - Prescaler input is the CPU clock when select is 0, external clock when 1.
// - Counter clock is prescaler input divided by two to the 3-bit divider.
// - Run enable 0 freezes prescaler and counter; 1 lets the counter run.
// - Force reload loads reload value, clears prescaler; bit always reads zero.
// - Overflow interrupt request is raised only while flag set and enable is 1.
// - Overflow flag sets on passing FFh to reload value; status read clears it.
// - Counter access reads the live counter; writes update it immediately.
// - Every overflow loads the software-written reload value into the counter.
// - At overflow reload each PWM output switches to its polarity-selected level.
// - Each of four PWM channels has its own output enable bit.
// - Polarity 0: high while counter at or below compare, else low; 1 inverts.
// - Changing a polarity bit inverts that PWM output at once.
// - Duty register sets second edge via compare; first edge is the reload value.
// - Upper two capture control bits are reserved and read zero.
// - Capture edge select 0 triggers on falling edge, 1 on rising edge.
// - Each capture channel has an interrupt enable gating its request.
// - Capture sets channel flag; reading that channel's result clears it.
// - Capture result holds counter value latched at the capture event.
// - Reset clears every timer register.
// - Duty registers are copied into hidden compare registers at every overflow.
// - After a capture, further captures are blocked until the result is read.
// - PWM period is 256 minus reload value counter clocks, shared by channels.
// - Writing the counter access register also clears the prescaler.
package pwmart_pkg;

  localparam int          PWMART_ADDR_W   = 12;
  localparam int          PWMART_CHANNELS = 4;
  localparam int          PWMART_CAPS     = 2;
  localparam int          PWMART_PRESC_W  = 7;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0]  IDX_DUTY3       = 10'h074;
  localparam logic [9:0]  IDX_DUTY0       = 10'h077;
  localparam logic [9:0]  IDX_PWM_CTRL    = 10'h078;
  localparam logic [9:0]  IDX_CTRL_STAT   = 10'h079;
  localparam logic [9:0]  IDX_COUNTER     = 10'h07A;
  localparam logic [9:0]  IDX_RELOAD      = 10'h07B;
  localparam logic [9:0]  IDX_CAP_CTRL    = 10'h07C;
  localparam logic [9:0]  IDX_CAP_RES1    = 10'h07D;
  localparam logic [9:0]  IDX_CAP_RES2    = 10'h07E;

  // Control/status field positions.
  localparam int          CS_EXT_SEL_BIT  = 7;
  localparam int          CS_DIV_LSB      = 4;
  localparam int          CS_RUN_BIT      = 3;
  localparam int          CS_FORCE_BIT    = 2;
  localparam int          CS_OIE_BIT      = 1;
  localparam int          CS_OVF_BIT      = 0;
  // PWM control and capture control field positions.
  localparam int          PC_OE_LSB       = 4;
  localparam int          PC_POL_LSB      = 0;
  localparam int          CC_SENSE_LSB    = 4;
  localparam int          CC_CIE_LSB      = 2;
  localparam int          CC_FLAG_LSB     = 0;

  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [7:0]  CNT_TOP         = 8'hFF;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic       external_clock_select;
    logic [2:0] count_clock_divider;
    logic       counter_run_enable;
    logic       overflow_irq_enable;
  } pwmart_ctrl_s;

  localparam pwmart_ctrl_s CTRL_RST = '0;

endpackage : pwmart_pkg

// *** pwmart_top.sv ***
// Auto-reload 8-bit timer with four PWM outputs, two input captures and an AXI4-Lite register slave.
// Assumes all pins are synchronous to aclk except the external clock and capture inputs, which are resynchronised.
`timescale 1ns/100ps
module pwmart_top
  import pwmart_pkg::*;
#(
  parameter int NCH  = PWMART_CHANNELS,
  parameter int NCAP = PWMART_CAPS
)(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [PWMART_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [PWMART_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     external_clock_in,
  input  wire logic [NCAP-1:0]          capture_input_pin,
  output logic [NCH-1:0]                pwm_output_pin,
  output logic [NCH-1:0]                pwm_output_oe_n,
  output logic                          overflow_irq,
  output logic [NCAP-1:0]               capture_irq
);

  logic                      awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]                bresp_q, rresp_q;
  logic [31:0]               rdata_q;
  logic [9:0]                wr_idx_q;
  logic [7:0]                wdata_q;
  logic                      wstrb0_q;
  logic                      wr_en, rd_en, wr_hit, rd_hit;
  logic [9:0]                rd_idx;
  logic [7:0]                rd_mux;

  pwmart_ctrl_s              ctrl_q;
  logic                      ovf_q, ovf_irq_q;
  logic [7:0]                cnt_q, reload_q;
  logic [PWMART_PRESC_W-1:0] presc_q, div_mask;
  logic [NCH-1:0]            oe_q, pol_q;
  logic [7:0]                duty_q [NCH];
  logic [7:0]                cmp_q  [NCH];
  logic [NCAP-1:0]           sense_q, cie_q, flag_q, cap_irq_q;
  logic [7:0]                capv_q [NCAP];
  logic [NCAP-1:0]           cap_s1_q, cap_s2_q, cap_s3_q, cap_evt, cap_take, cap_rd;
  logic                      ext_s1_q, ext_s2_q, ext_s3_q;
  logic                      in_tick, cnt_tick, overflow;
  logic                      wr_ctrl, wr_cnt, wr_pwm, wr_reload, wr_capc, force_rl, rd_ctrl;
  logic [NCH-1:0]            pwm_q, pwm_oe_n_q;

  // Write path: address and data are taken independently and held until the response is accepted.
  assign wr_en = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      wr_idx_q  <= '0;
      wdata_q   <= RST_BYTE;
      wstrb0_q  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awready_q <= 1'b0;
        wr_idx_q  <= s_axi_awaddr[PWMART_ADDR_W-1:2];
      end
      if (s_axi_wvalid && wready_q)
      begin
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_en)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  assign wr_hit    = (wr_idx_q >= IDX_DUTY3) && (wr_idx_q <= IDX_CAP_RES2);
  assign wr_ctrl   = wr_en && wstrb0_q && (wr_idx_q == IDX_CTRL_STAT);
  assign wr_cnt    = wr_en && wstrb0_q && (wr_idx_q == IDX_COUNTER);
  assign wr_pwm    = wr_en && wstrb0_q && (wr_idx_q == IDX_PWM_CTRL);
  assign wr_reload = wr_en && wstrb0_q && (wr_idx_q == IDX_RELOAD);
  assign wr_capc   = wr_en && wstrb0_q && (wr_idx_q == IDX_CAP_CTRL);
  assign force_rl  = wr_ctrl && wdata_q[CS_FORCE_BIT];

  // Read path: one read in flight; the data word is sampled in the cycle the address is taken.
  assign rd_en   = s_axi_arvalid && arready_q;
  assign rd_idx  = s_axi_araddr[PWMART_ADDR_W-1:2];
  assign rd_hit  = (rd_idx >= IDX_DUTY3) && (rd_idx <= IDX_CAP_RES2);
  assign rd_ctrl = rd_en && (rd_idx == IDX_CTRL_STAT);
  assign cap_rd  = {rd_en && (rd_idx == IDX_CAP_RES2), rd_en && (rd_idx == IDX_CAP_RES1)};

  always_comb
  begin
    rd_mux = RST_BYTE;
    unique case (rd_idx)
      IDX_PWM_CTRL:  rd_mux = {oe_q, pol_q};
      IDX_CTRL_STAT: rd_mux = {ctrl_q.external_clock_select, ctrl_q.count_clock_divider,
                               ctrl_q.counter_run_enable, 1'b0, ctrl_q.overflow_irq_enable, ovf_q};
      IDX_COUNTER:   rd_mux = cnt_q;
      IDX_RELOAD:    rd_mux = reload_q;
      IDX_CAP_CTRL:  rd_mux = {2'b00, sense_q, cie_q, flag_q};
      IDX_CAP_RES1:  rd_mux = capv_q[0];
      IDX_CAP_RES2:  rd_mux = capv_q[1];
      default:
      begin
        if (rd_idx >= IDX_DUTY3 && rd_idx <= IDX_DUTY0)
          rd_mux = duty_q[2'(IDX_DUTY0 - rd_idx)];
        else
          rd_mux = RST_BYTE;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end
    else if (rd_en)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_mux};
      rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Control and configuration registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q   <= CTRL_RST;
      reload_q <= RST_BYTE;
      oe_q     <= '0;
      pol_q    <= '0;
      sense_q  <= '0;
      cie_q    <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q.external_clock_select <= wdata_q[CS_EXT_SEL_BIT];
        ctrl_q.count_clock_divider   <= wdata_q[CS_DIV_LSB +: 3];
        ctrl_q.counter_run_enable    <= wdata_q[CS_RUN_BIT];
        ctrl_q.overflow_irq_enable   <= wdata_q[CS_OIE_BIT];
      end
      if (wr_reload)
        reload_q <= wdata_q;
      if (wr_pwm)
      begin
        oe_q  <= wdata_q[PC_OE_LSB +: NCH];
        pol_q <= wdata_q[PC_POL_LSB +: NCH];
      end
      if (wr_capc)
      begin
        sense_q <= wdata_q[CC_SENSE_LSB +: NCAP];
        cie_q   <= wdata_q[CC_CIE_LSB +: NCAP];
      end
    end
  end

  // Input synchronisers; only the second and third stages feed edge detection.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      cap_s1_q <= '0;
      cap_s2_q <= '0;
      cap_s3_q <= '0;
    end
    else
    begin
      ext_s1_q <= external_clock_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      cap_s1_q <= capture_input_pin;
      cap_s2_q <= cap_s1_q;
      cap_s3_q <= cap_s2_q;
    end
  end

  // The external clock is counted on its rising edge, so it must stay below half of aclk.
  assign in_tick  = ctrl_q.external_clock_select ? (ext_s2_q && !ext_s3_q) : 1'b1;
  assign div_mask = PWMART_PRESC_W'((8'h01 << ctrl_q.count_clock_divider) - 8'h01);
  assign cnt_tick = ctrl_q.counter_run_enable && in_tick && ((presc_q | ~div_mask) == '1);
  assign overflow = cnt_tick && (cnt_q == CNT_TOP) && !wr_cnt && !force_rl;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      presc_q <= '0;
    else if (wr_cnt || force_rl)
      presc_q <= '0;
    else if (ctrl_q.counter_run_enable && in_tick)
      presc_q <= presc_q + 1'b1;
  end

  // Software writes win over a coinciding count or overflow.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= RST_BYTE;
    else if (wr_cnt)
      cnt_q <= wdata_q;
    else if (force_rl)
      cnt_q <= reload_q;
    else if (overflow)
      cnt_q <= reload_q;
    else if (cnt_tick)
      cnt_q <= cnt_q + 8'h01;
  end

  // A new overflow in the cycle of a status read keeps the flag set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovf_q     <= 1'b0;
      ovf_irq_q <= 1'b0;
    end
    else
    begin
      if (overflow)
        ovf_q <= 1'b1;
      else if (rd_ctrl)
        ovf_q <= 1'b0;
      ovf_irq_q <= ovf_q && ctrl_q.overflow_irq_enable;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_pwm
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          duty_q[ch]     <= RST_BYTE;
          cmp_q[ch]      <= RST_BYTE;
          pwm_q[ch]      <= 1'b0;
          pwm_oe_n_q[ch] <= 1'b1;
        end
        else
        begin
          if (wr_en && wstrb0_q && (wr_idx_q == IDX_DUTY0 - 10'(ch)))
            duty_q[ch] <= wdata_q;
          if (overflow)
            cmp_q[ch] <= duty_q[ch];
          // Level follows the live counter, so the reload edge and polarity changes show at once.
          pwm_q[ch]      <= oe_q[ch] && ((cnt_q <= cmp_q[ch]) ^ pol_q[ch]);
          pwm_oe_n_q[ch] <= !oe_q[ch];
        end
      end
    end
  endgenerate

  genvar cp;
  generate
    for (cp = 0; cp < NCAP; cp++)
    begin : g_cap
      assign cap_evt[cp]  = sense_q[cp] ? (cap_s2_q[cp] && !cap_s3_q[cp])
                                        : (!cap_s2_q[cp] && cap_s3_q[cp]);
      // A read in the same cycle reopens the register, so that event is kept.
      assign cap_take[cp] = cap_evt[cp] && (!flag_q[cp] || cap_rd[cp]);

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          capv_q[cp]    <= RST_BYTE;
          flag_q[cp]    <= 1'b0;
          cap_irq_q[cp] <= 1'b0;
        end
        else
        begin
          if (cap_take[cp])
            capv_q[cp] <= cnt_q;
          if (cap_take[cp])
            flag_q[cp] <= 1'b1;
          else if (cap_rd[cp])
            flag_q[cp] <= 1'b0;
          cap_irq_q[cp] <= flag_q[cp] && cie_q[cp];
        end
      end
    end
  endgenerate

  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rdata     = rdata_q;
  assign s_axi_rresp     = rresp_q;
  assign pwm_output_pin  = pwm_q;
  assign pwm_output_oe_n = pwm_oe_n_q;
  assign overflow_irq    = ovf_irq_q;
  assign capture_irq     = cap_irq_q;

endmodule : pwmart_top

// *** tb.sv ***
// Self-checking bench for the auto-reload PWM timer: AXI4-Lite register tasks and directed tests.
// Assumes the far-side model supplies count clock, capture signals and PWM loads.
`timescale 1ns/100ps
module tb;
  import pwmart_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, external_clock_in;
  logic        overflow_irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, h0, h1;
  logic [3:0]  s_axi_wstrb, pwm_output_pin, pwm_output_oe_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp, capture_input_pin, capture_irq;
  int          err_total, checks;

  pwmart_top pwmart_top_inst (.*);
  pwmart_far_side pwmart_far_side_inst (
    .aclk      (aclk),
    .pwm_level (pwm_output_pin),
    .pwm_oe_n  (pwm_output_oe_n),
    .ext_clk   (external_clock_in),
    .cap_level (capture_input_pin)
  );

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // The response ready is raised late on purpose so the slave must hold its answer.
  task automatic wr(input logic [9:0] ix, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr  <= {ix, 2'b00};
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    cmp("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : wr

  task automatic rd(input logic [9:0] ix, output logic [31:0] d, output logic [1:0] rr);
    s_axi_araddr  <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    d  = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : rd

  task automatic rc(input logic [9:0] ix, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  rr;
    rd(ix, d, rr);
    cmp("rdata", {24'h00_0000, e}, d);
    cmp("rresp", 32'(er), 32'(rr));
  endtask : rc

  task automatic hi(output logic [31:0] c0, output logic [31:0] c1);
    c0 = pwmart_far_side_inst.hi_cnt[0];
    c1 = pwmart_far_side_inst.hi_cnt[1];
    cyc(256);
    c0 = pwmart_far_side_inst.hi_cnt[0] - c0;
    c1 = pwmart_far_side_inst.hi_cnt[1] - c1;
  endtask : hi

  task automatic cap(input int i, input logic v);
    pwmart_far_side_inst.set_cap(i, v);
    cyc(6);
  endtask : cap

  task automatic complete_run;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // The tests need about 2700 cycles; over seven times that means a hang.
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    complete_run;
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = IDX_DUTY3; i <= IDX_CAP_RES2; i++)
      rc(10'(i), 8'h00);
    rc(10'h000, 8'h00, RESP_SLVERR);
    wr(10'h000, 8'h55, RESP_SLVERR);
    wr(IDX_RELOAD, 8'hF0);
    wr(IDX_CTRL_STAT, 8'h04);
    rc(IDX_CTRL_STAT, 8'h00);
    rc(IDX_COUNTER, 8'hF0);
    cyc(20);
    rc(IDX_COUNTER, 8'hF0);
    wr(IDX_CTRL_STAT, 8'h78);
    wr(IDX_COUNTER, 8'h10);
    rc(IDX_COUNTER, 8'h10);
    cyc(130);
    rc(IDX_COUNTER, 8'h11);
    wr(IDX_CTRL_STAT, 8'h00);
    wr(IDX_RELOAD, 8'h00);
    wr(IDX_COUNTER, 8'hFE);
    wr(IDX_CTRL_STAT, 8'h0A);
    cyc(4);
    cmp("ovf_irq", 32'h0000_0001, 32'(overflow_irq));
    rc(IDX_CTRL_STAT, 8'h0B);
    wr(IDX_CTRL_STAT, 8'h08);
    cyc(300);
    cmp("ovf_irq", 32'h0000_0000, 32'(overflow_irq));
    rc(IDX_CTRL_STAT, 8'h09);
    wr(IDX_DUTY0, 8'h80);
    wr(IDX_PWM_CTRL, 8'h12);
    wr(IDX_CTRL_STAT, 8'h0C);
    cyc(300);
    hi(h0, h1);
    cmp("pwm0_high", 32'h0000_0081, h0);
    cmp("pwm1_high", 32'h0000_0000, h1);
    cmp("oe_n", 32'h0000_000E, 32'(pwm_output_oe_n));
    wr(IDX_PWM_CTRL, 8'h13);
    hi(h0, h1);
    cmp("pwm0_high", 32'h0000_007F, h0);
    wr(IDX_DUTY0, 8'h40);
    cyc(300);
    hi(h0, h1);
    cmp("pwm0_high", 32'h0000_00BF, h0);
    wr(IDX_RELOAD, 8'hC0);
    wr(IDX_DUTY0, 8'hE0);
    cyc(300);
    hi(h0, h1);
    cmp("pwm0_high", 32'h0000_007C, h0);
    wr(IDX_CTRL_STAT, 8'h00);
    wr(IDX_COUNTER, 8'h5A);
    wr(IDX_CAP_CTRL, 8'h14);
    cap(0, 1'b1);
    cmp("cap_irq", 32'h0000_0001, 32'(capture_irq));
    rc(IDX_CAP_CTRL, 8'h15);
    wr(IDX_COUNTER, 8'h33);
    cap(0, 1'b0);
    cap(0, 1'b1);
    rc(IDX_CAP_RES1, 8'h5A);
    rc(IDX_CAP_CTRL, 8'h14);
    cap(0, 1'b0);
    cap(0, 1'b1);
    rc(IDX_CAP_RES1, 8'h33);
    cap(1, 1'b1);
    rc(IDX_CAP_CTRL, 8'h14);
    cap(1, 1'b0);
    rc(IDX_CAP_CTRL, 8'h16);
    cmp("cap_irq", 32'h0000_0000, 32'(capture_irq));
    rc(IDX_CAP_RES2, 8'h33);
    wr(IDX_CAP_CTRL, 8'hFC);
    rc(IDX_CAP_CTRL, 8'h3C);
    wr(IDX_COUNTER, 8'h00);
    wr(IDX_CTRL_STAT, 8'h88);
    cyc(10);
    rc(IDX_COUNTER, 8'h00);
    pwmart_far_side_inst.ext_burst(5);
    cyc(8);
    rc(IDX_COUNTER, 8'h05);
    complete_run;
  end
endmodule : tb
